// file: core/exec_consts.vh
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
// opcode patterns and masks on the 14-bit word
`define OPC_ADD_LIT_MASK  14'h3e00
`define OPC_ADD_LIT_VAL   14'h3e00
`define OPC_AND_LIT_MASK  14'h3f00
`define OPC_AND_LIT_VAL   14'h3900
`define OPC_ADD_FILE_MASK 14'h3f00
`define OPC_ADD_FILE_VAL  14'h0700
`define OPC_AND_FILE_MASK 14'h3f00
`define OPC_AND_FILE_VAL  14'h0500
`define OPC_BCLR_MASK     14'h3c00
`define OPC_BCLR_VAL      14'h1000
// field positions
`define DEST_BIT          7
`define FADDR_MSB         6
`define BPOS_MSB          9
`define BPOS_LSB          7
`define LIT_MSB           7
// reset values and file depth
`define ACC_RESET         8'h00
`define FILE_RESET        8'h00
`define FILE_DEPTH        128
`endif

// file: core/file_ram.v
`include "exec_consts.vh"
module file_ram (
	input  wire       clock_i,
	input  wire [6:0] raddr_i,
	input  wire       we_i,
	input  wire [6:0] waddr_i,
	input  wire [7:0] wdata_i,
	output reg  [7:0] rdata_o
);
	reg [7:0] mem [0:`FILE_DEPTH-1];
	// registered read; write-through so a same-address read sees new data
	always @(posedge clock_i) begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		if (we_i && waddr_i == raddr_i)
			rdata_o <= wdata_i;
		else
			rdata_o <= mem[raddr_i];
	end
endmodule

// file: core/add_and_bitclear_exec.v
`include "exec_consts.vh"
// How it works
// - literal add into accumulator, all three flags
// - literal AND into accumulator, Z only
// - file add to chosen destination, three flags
// - dest bit zero accumulator, one file
// - file AND to chosen destination, Z only
// - clear chosen file bit, flags untouched
// - seven-bit file address, three-bit bit index
module add_and_bitclear_exec (
	input  wire        clock_i,
	input  wire        reset_i,
	input  wire        instr_valid_i,
	input  wire [13:0] instr_i,
	output reg  [7:0]  acc_o,
	output reg         carry_flag_o,
	output reg         half_carry_flag_o,
	output reg         zero_flag_o,
	output reg         file_we_o,
	output reg  [6:0]  file_waddr_o,
	output reg  [7:0]  file_wdata_o,
	output reg         done_o
);
	localparam ST_FETCH = 1'b0;
	localparam ST_EXEC  = 1'b1;

	function match;
		input [13:0] word;
		input [13:0] mask;
		input [13:0] val;
		begin
			match = (word & mask) == val;
		end
	endfunction

	function [9:0] add9;
		input [7:0] a;
		input [7:0] b;
		reg   [4:0] lo;
		reg   [8:0] full;
		begin
			// half carry is the carry out of bit 3, from a nibble sum
			lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
			full = {1'b0, a} + {1'b0, b};
			add9 = {lo[4], full};
		end
	endfunction

	// zero test shared by every flag update
	function is_zero;
		input [7:0] v;
		begin
			is_zero = v == 8'h00;
		end
	endfunction

	// one-hot mask of the bit to clear
	function [7:0] bit_mask;
		input [2:0] pos;
		begin
			bit_mask = 8'h01 << pos;
		end
	endfunction

	reg         state_reg;
	reg  [13:0] ir_reg;
	reg  [7:0]  acc_reg;
	reg         c_reg;
	reg         hc_reg;
	reg         z_reg;
	wire [7:0]  file_rdata;
	reg         mem_we;
	reg  [7:0]  mem_wdata;

	wire [6:0]  faddr  = ir_reg[`FADDR_MSB:0];
	wire [2:0]  bpos   = ir_reg[`BPOS_MSB:`BPOS_LSB];
	wire [7:0]  lit    = ir_reg[`LIT_MSB:0];
	wire        to_file = ir_reg[`DEST_BIT];
	wire [6:0]  raddr  = instr_i[`FADDR_MSB:0];

	// literal add ignores bit 8, so its mask is one bit shorter
	wire is_addl  = match(ir_reg, `OPC_ADD_LIT_MASK, `OPC_ADD_LIT_VAL);
	wire is_andl  = match(ir_reg, `OPC_AND_LIT_MASK, `OPC_AND_LIT_VAL);
	wire is_addf  = match(ir_reg, `OPC_ADD_FILE_MASK, `OPC_ADD_FILE_VAL);
	wire is_andf  = match(ir_reg, `OPC_AND_FILE_MASK, `OPC_AND_FILE_VAL);
	wire is_bclr  = match(ir_reg, `OPC_BCLR_MASK, `OPC_BCLR_VAL);

	wire [9:0] sum_l = add9(acc_reg, lit);
	wire [9:0] sum_f = add9(acc_reg, file_rdata);
	wire [7:0] and_l = acc_reg & lit;
	wire [7:0] and_f = acc_reg & file_rdata;

	// file operand is read while the word is latched, so execution
	// takes exactly the following cycle with no bubble
	file_ram u_file_ram (
		.clock_i (clock_i),
		.raddr_i (raddr),
		.we_i    (mem_we),
		.waddr_i (faddr),
		.wdata_i (mem_wdata),
		.rdata_o (file_rdata)
	);

	reg [7:0] acc_next;
	reg       c_next;
	reg       hc_next;
	reg       z_next;
	always @* begin
		// flags hold unless the decoded word updates them
		acc_next  = acc_reg;
		c_next    = c_reg;
		hc_next   = hc_reg;
		z_next    = z_reg;
		mem_we    = 1'b0;
		mem_wdata = file_rdata;
		if (state_reg == ST_EXEC) begin
			if (is_addl) begin
				acc_next = sum_l[7:0];
				c_next   = sum_l[8];
				hc_next  = sum_l[9];
				z_next   = is_zero(sum_l[7:0]);
			end else if (is_andl) begin
				acc_next = and_l;
				z_next   = is_zero(and_l);
			end else if (is_addf) begin
				c_next  = sum_f[8];
				hc_next = sum_f[9];
				z_next  = is_zero(sum_f[7:0]);
				if (to_file) begin
					mem_we    = 1'b1;
					mem_wdata = sum_f[7:0];
				end else
					acc_next = sum_f[7:0];
			end else if (is_andf) begin
				z_next = is_zero(and_f);
				if (to_file) begin
					mem_we    = 1'b1;
					mem_wdata = and_f;
				end else
					acc_next = and_f;
			end else if (is_bclr) begin
				mem_we    = 1'b1;
				mem_wdata = file_rdata & ~bit_mask(bpos);
			end
			// any other word retires as a no-op, done still pulses
		end
	end

	// one fetch cycle plus one execute cycle, never stalled
	// a word is taken in either state, so words retire one per cycle
	always @(posedge clock_i) begin
		if (reset_i) begin
			// no decoded pattern is all zero, so a cleared word is inert
			state_reg <= ST_FETCH;
			ir_reg    <= 14'h0000;
		end else begin
			case (state_reg)
			ST_FETCH: begin
				if (instr_valid_i) begin
					ir_reg    <= instr_i;
					state_reg <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				// back-to-back words: a new one may be taken right away
				if (instr_valid_i) begin
					ir_reg    <= instr_i;
					state_reg <= ST_EXEC;
				end else
					state_reg <= ST_FETCH;
			end
			default: state_reg <= ST_FETCH;
			endcase
		end
	end

	// working accumulator and flags feed the next execute cycle
	always @(posedge clock_i) begin
		if (reset_i) begin
			acc_reg <= `ACC_RESET;
			c_reg   <= 1'b0;
			hc_reg  <= 1'b0;
			z_reg   <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			c_reg   <= c_next;
			hc_reg  <= hc_next;
			z_reg   <= z_next;
		end
	end

	// outputs copy the next values, so they change on the same edge
	// as the internal state rather than one cycle behind it
	always @(posedge clock_i) begin
		if (reset_i) begin
			acc_o             <= `ACC_RESET;
			carry_flag_o      <= 1'b0;
			half_carry_flag_o <= 1'b0;
			zero_flag_o       <= 1'b0;
			file_we_o         <= 1'b0;
			file_waddr_o      <= 7'h00;
			file_wdata_o      <= `FILE_RESET;
			done_o            <= 1'b0;
		end else begin
			acc_o             <= acc_next;
			carry_flag_o      <= c_next;
			half_carry_flag_o <= hc_next;
			zero_flag_o       <= z_next;
			file_we_o         <= mem_we;
			file_waddr_o      <= faddr;
			file_wdata_o      <= mem_wdata;
			done_o            <= state_reg == ST_EXEC;
		end
	end
endmodule

// file: verification/exec_checker_properties.sv
module exec_checker (
	input wire        clock_i,
	input wire        reset_i,
	input wire        instr_valid_i,
	input wire [13:0] instr_i,
	input wire [7:0]  acc_o,
	input wire        carry_flag_o,
	input wire        half_carry_flag_o,
	input wire        zero_flag_o,
	input wire        file_we_o,
	input wire [6:0]  file_waddr_o,
	input wire [7:0]  file_wdata_o,
	input wire        done_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence lit_add;
		instr_valid_i && instr_i[13:9] == 5'h1f;
	endsequence
	sequence lit_and;
		instr_valid_i && instr_i[13:8] == 6'h39;
	endsequence
	sequence file_to_acc;
		instr_valid_i && !instr_i[7] &&
			(instr_i[13:8] == 6'h07 || instr_i[13:8] == 6'h05);
	endsequence
	sequence file_to_reg;
		instr_valid_i && instr_i[7] &&
			(instr_i[13:8] == 6'h07 || instr_i[13:8] == 6'h05);
	endsequence
	sequence bit_clr;
		instr_valid_i && instr_i[13:10] == 4'h4;
	endsequence
	// a word taken at one edge shows its result two edges later
	a_done_follows: assert property (
		instr_valid_i |-> ##2 done_o)
		else $error("no done");
	a_done_cause: assert property (
		done_o |-> $past(instr_valid_i, 2))
		else $error("stray done");
	a_add_zero: assert property (
		lit_add |-> ##2 zero_flag_o == (acc_o == 8'h00))
		else $error("add zero");
	a_and_mask: assert property (
		lit_and |-> ##2 (acc_o & ~$past(instr_i[7:0], 2)) == 8'h00)
		else $error("and mask");
	a_dest_acc: assert property (
		file_to_acc |-> ##2 !file_we_o)
		else $error("dest acc");
	a_dest_file: assert property (
		file_to_reg |-> ##2 file_we_o && $stable(acc_o) &&
			file_waddr_o == $past(instr_i[6:0], 2))
		else $error("dest file");
	a_clr_bit: assert property (
		bit_clr |-> ##2 file_we_o &&
			!file_wdata_o[$past(instr_i[9:7], 2)])
		else $error("bit clear");
	a_clr_flags: assert property (
		bit_clr |-> ##2 $stable({carry_flag_o, half_carry_flag_o,
			zero_flag_o, acc_o}))
		else $error("clear flags");
endmodule
bind add_and_bitclear_exec exec_checker u_exec_checker (
	.clock_i           (clock_i),
	.reset_i           (reset_i),
	.instr_valid_i     (instr_valid_i),
	.instr_i           (instr_i),
	.acc_o             (acc_o),
	.carry_flag_o      (carry_flag_o),
	.half_carry_flag_o (half_carry_flag_o),
	.zero_flag_o       (zero_flag_o),
	.file_we_o         (file_we_o),
	.file_waddr_o      (file_waddr_o),
	.file_wdata_o      (file_wdata_o),
	.done_o            (done_o)
);

// file: verification/tb_add_and_bitclear_exec.sv
module tb_add_and_bitclear_exec;
	timeunit 1ns;
	timeprecision 1ns;
	reg         clock_i = 1'b0;
	reg         reset_i = 1'b1;
	reg         instr_valid_i = 1'b0;
	reg  [13:0] instr_i = 14'h0000;
	wire [7:0]  acc_o;
	wire        c_o, h_o, z_o, we_o, done_o;
	wire [6:0]  waddr_o;
	wire [7:0]  wdata_o;
	wire [12:0] state_seen = {acc_o, c_o, h_o, z_o, we_o, done_o};
	integer     fail_count = 0;
	integer     cmp_count = 0;
	always #20 clock_i = ~clock_i;
	add_and_bitclear_exec u_add_and_bitclear_exec (.clock_i(clock_i),
		.reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.acc_o(acc_o), .carry_flag_o(c_o), .half_carry_flag_o(h_o),
		.zero_flag_o(z_o), .file_we_o(we_o), .file_waddr_o(waddr_o),
		.file_wdata_o(wdata_o), .done_o(done_o));
	task conclude;
		begin
			$display("mismatches %0d compares %0d", fail_count, cmp_count);
			if (fail_count == 0 && cmp_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input [15:0] seen, input [15:0] want);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== want) begin
				fail_count = fail_count + 1;
				$display("Error %0t got %h want %h", $time, seen, want);
			end
		end
	endtask
	// one word, then wait a bounded time for its done pulse
	task run(input [13:0] w, input [7:0] a, input [2:0] f, input [8:0] wr);
		integer n;
		begin
			instr_valid_i = 1'b1;
			instr_i = w;
			@(negedge clock_i);
			instr_valid_i = 1'b0;
			n = 0;
			while (done_o !== 1'b1 && n < 4) begin
				@(negedge clock_i);
				n = n + 1;
			end
			if (n == 4) begin
				chk(16'h0000, 16'h0001);
				conclude;
			end else begin
				chk(n[15:0], 16'h0001);
				chk({acc_o, c_o, h_o, z_o, we_o}, {a, f, wr[8]});
				if (wr[8])
					chk({1'b0, waddr_o, wdata_o}, {1'b0, w[6:0], wr[7:0]});
			end
		end
	endtask
	// three words on consecutive edges: the second writes the file
	// register that the third reads, so the write must be forwarded
	task back_to_back;
		begin
			instr_valid_i = 1'b1;
			instr_i = 14'h3e05;
			@(negedge clock_i);
			instr_i = 14'h07ff;
			@(negedge clock_i);
			instr_i = 14'h077f;
			chk(state_seen, {8'h45, 3'h0, 1'b0, 1'b1});
			@(negedge clock_i);
			instr_valid_i = 1'b0;
			chk(state_seen, {8'h45, 3'h0, 1'b1, 1'b1});
			chk({1'b0, waddr_o, wdata_o}, {1'b0, 7'h7f, 8'h85});
			@(negedge clock_i);
			chk(state_seen, {8'hca, 3'h0, 1'b0, 1'b1});
			@(negedge clock_i);
			chk({15'h0000, done_o}, 16'h0000);
		end
	endtask
	// an unknown word changes nothing; a mid-run reset clears outputs
	task refused_then_reset;
		begin
			run(14'h3a55, 8'hca, 3'h0, 9'h000);
			reset_i = 1'b1;
			repeat (2) @(negedge clock_i);
			chk(state_seen, 13'h0000);
			chk({1'b0, waddr_o, wdata_o}, 16'h0000);
			reset_i = 1'b0;
			run(14'h3e01, 8'h01, 3'h0, 9'h000);
		end
	endtask
	task literal_ops;
		begin
			run(14'h3e10, 8'h10, 3'h0, 9'h000);
			run(14'h3f15, 8'h25, 3'h0, 9'h000);
			run(14'h3fdb, 8'h00, 3'h7, 9'h000);
			run(14'h395f, 8'h00, 3'h7, 9'h000);
			run(14'h3ea3, 8'ha3, 3'h0, 9'h000);
			run(14'h395f, 8'h03, 3'h0, 9'h000);
			run(14'h390c, 8'h00, 3'h1, 9'h000);
		end
	endtask
	task file_ops;
		begin
			run(14'h05ff, 8'h00, 3'h1, 9'h100);
			run(14'h3ec2, 8'hc2, 3'h0, 9'h000);
			run(14'h07ff, 8'hc2, 3'h0, 9'h1c2);
			run(14'h3e55, 8'h17, 3'h4, 9'h000);
			run(14'h13ff, 8'h17, 3'h4, 9'h142);
			run(14'h10ff, 8'h17, 3'h4, 9'h140);
			run(14'h077f, 8'h57, 3'h0, 9'h000);
			run(14'h05ff, 8'h57, 3'h0, 9'h140);
			run(14'h057f, 8'h40, 3'h0, 9'h000);
		end
	endtask
	initial begin
		repeat (20) @(negedge clock_i);
		reset_i = 1'b0;
		literal_ops;
		file_ops;
		back_to_back;
		refused_then_reset;
		conclude;
	end
endmodule
